// ### src/nfc_fifo_pkg.sv
// constants, field layouts and states for the 96-byte frame fifo block
package nfc_fifo_pkg;

  // fifo geometry
  localparam int FIFO_DEPTH = 96;
  localparam int CNT_W      = 7;
  localparam int NTX_W      = 13;

  // water levels, two per direction; plain defaults
  localparam logic [6:0] WL_RX_0    = 7'h40;
  localparam logic [6:0] WL_RX_1    = 7'h50;
  localparam logic [6:0] WL_TX_0    = 7'h20;
  localparam logic [6:0] WL_TX_1    = 7'h10;
  localparam logic [6:0] TX_LOW_MRK = 7'h04;

  // serial port mode and code fields
  localparam logic [1:0] MODE_FIFO  = 2'h2;
  localparam logic [1:0] MODE_CMD   = 2'h3;
  localparam logic [5:0] CODE_LOAD  = 6'h00;
  localparam logic [5:0] CODE_READ  = 6'h3f;
  localparam logic [5:0] CMD_CLR_A  = 6'h02;
  localparam logic [5:0] CMD_CLR_B  = 6'h03;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_NTX    = 8'h04;
  localparam logic [7:0] OFF_FSTAT1 = 8'h08;
  localparam logic [7:0] OFF_FSTAT2 = 8'h0c;
  localparam logic [7:0] OFF_ISTAT  = 8'h10;
  localparam logic [7:0] OFF_IMASK  = 8'h14;

  // interrupt bit positions and reset values
  localparam int         IRQ_W      = 3;
  localparam int         IRQ_WL     = 0;
  localparam int         IRQ_OVR    = 1;
  localparam int         IRQ_UNF    = 2;
  localparam logic [2:0] IMASK_RST  = 3'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVER = 2'h2;

  // control register layout
  typedef struct packed {
    logic wl_tx_sel;
    logic wl_rx_sel;
    logic en;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 3'h0;

  // second fifo status register layout
  typedef struct packed {
    logic       underflow;
    logic       overflow;
    logic       last_byte_parity_flag;
    logic [2:0] last_byte_valid_bits;
    logic       last_byte_incomplete;
  } fstat2_t;
  localparam fstat2_t FSTAT2_RST = 7'h00;

  // serial port states
  typedef enum logic [2:0] {
    SPI_IDLE = 3'b000,
    SPI_CMD  = 3'b001,
    SPI_LOAD = 3'b010,
    SPI_READ = 3'b011,
    SPI_SKIP = 3'b100
  } spi_state_t;

  // register index from address decode
  typedef enum logic [2:0] {
    RI_CTRL   = 3'b000,
    RI_NTX    = 3'b001,
    RI_FSTAT1 = 3'b010,
    RI_FSTAT2 = 3'b011,
    RI_ISTAT  = 3'b100,
    RI_IMASK  = 3'b101,
    RI_NONE   = 3'b111
  } reg_idx_t;

endpackage

// ### src/nfc_frame_fifo.sv
// frame fifo with water-level interrupts, serial host port and axi4-lite registers
`timescale 1ns/1ps
module nfc_frame_fifo
  import nfc_fifo_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // serial host port (asynchronous pins)
  input  wire logic        sclk_i,
  input  wire logic        ss_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_n_o,
  // receive path from demodulator and framing
  input  wire logic        rx_active_i,
  input  wire logic        rx_start_i,
  input  wire logic        rx_byte_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_end_i,
  input  wire logic [2:0]  rx_last_bits_i,
  input  wire logic        rx_parity_i,
  // transmit path to framing
  input  wire logic        tx_active_i,
  input  wire logic        tx_req_i,
  output logic [7:0]       tx_data_o,
  output logic             tx_valid_o,
  // interrupt
  output logic             irq_o
);

  // address decode shared by read and write channels
  function automatic reg_idx_t decode(input logic [7:0] a);
    if (a == OFF_CTRL) decode = RI_CTRL;
    else if (a == OFF_NTX) decode = RI_NTX;
    else if (a == OFF_FSTAT1) decode = RI_FSTAT1;
    else if (a == OFF_FSTAT2) decode = RI_FSTAT2;
    else if (a == OFF_ISTAT) decode = RI_ISTAT;
    else if (a == OFF_IMASK) decode = RI_IMASK;
    else decode = RI_NONE;
  endfunction

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  // pin synchronisers: stage one feeds stage two only
  logic              sclk_s1, sclk_s2, sclk_d;
  logic              ss_s1, ss_s2;
  logic              mosi_s1, mosi_s2;
  // fifo storage and pointers
  logic [7:0]        mem [FIFO_DEPTH];
  logic [CNT_W-1:0]  wr_ptr_reg, wr_ptr_next;
  logic [CNT_W-1:0]  rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0]  count_reg, count_next;      // 0..96 unread bytes
  logic [NTX_W-1:0]  load_cnt_reg, load_cnt_next; // bytes loaded by host
  // serial port
  spi_state_t        spi_state_reg, spi_state_next;
  logic [2:0]        bit_cnt_reg, bit_cnt_next;
  logic [7:0]        in_shift_reg, in_shift_next;
  logic [7:0]        out_shift_reg, out_shift_next;
  logic              miso_oe_n_reg, miso_oe_n_next;
  // registers
  ctrl_t             ctrl_reg, ctrl_next;
  logic [NTX_W-1:0]  ntx_reg, ntx_next;
  fstat2_t           fstat2_reg, fstat2_next;
  logic [IRQ_W-1:0]  istat_reg, istat_next;
  logic [IRQ_W-1:0]  imask_reg, imask_next;
  logic              irq_reg, irq_next;
  // axi state
  logic              aw_have_reg, aw_have_next;
  logic [7:0]        aw_addr_reg, aw_addr_next;
  logic              w_have_reg, w_have_next;
  logic [31:0]       w_data_reg, w_data_next;
  logic [3:0]        w_strb_reg, w_strb_next;
  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  // transmit output
  logic [7:0]        tx_data_reg, tx_data_next;
  logic              tx_valid_reg, tx_valid_next;
  // combinational helpers
  logic              sclk_rise, sclk_fall;
  logic [7:0]        in_byte, head, wdata;
  logic              spi_wr, spi_rd, cmd_clear, fifo_clear;
  logic              wr_en, rd_en, do_wr, do_rd, full, empty;
  logic              ovr_ev, unf_ev, wl_ev, fifo_mode, loaded;
  logic [6:0]        wl_rx, wl_tx;
  reg_idx_t          widx, ridx;

  // the sclk is sampled only after two flops; edges come from stage two and its delay
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      ss_s1   <= 1'b1;
      ss_s2   <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      ss_s1   <= ss_n_i;
      ss_s2   <= ss_s1;
      mosi_s1 <= mosi_i;
      mosi_s2 <= mosi_s1;
    end
  end

  // fifo storage: flip-flops indexed by the write pointer, no reset needed
  always_ff @(posedge ref_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= wdata;
    end
  end

  // next-state logic for port, fifo, registers and bus
  always_comb begin
    sclk_rise = sclk_s2 & ~sclk_d;
    sclk_fall = ~sclk_s2 & sclk_d;
    in_byte   = {in_shift_reg[6:0], mosi_s2};
    head      = mem[rd_ptr_reg];
    full      = (count_reg == CNT_W'(FIFO_DEPTH));
    empty     = (count_reg == '0); // set before the port reads it
    spi_state_next = spi_state_reg;
    bit_cnt_next   = bit_cnt_reg;
    in_shift_next  = in_shift_reg;
    out_shift_next = out_shift_reg;
    spi_wr    = 1'b0;
    spi_rd    = 1'b0;
    cmd_clear = 1'b0;
    // serial port: select high always returns the port to idle
    if (ss_s2) begin
      spi_state_next = SPI_IDLE;
      bit_cnt_next   = 3'h0;
    end else if (spi_state_reg == SPI_IDLE) begin
      spi_state_next = SPI_CMD;
    end else if (sclk_rise) begin
      in_shift_next = in_byte;
      bit_cnt_next  = bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        case (spi_state_reg)
          SPI_CMD: begin
            if (in_byte == {MODE_FIFO, CODE_LOAD}) begin
              spi_state_next = SPI_LOAD;
            end else if (in_byte == {MODE_FIFO, CODE_READ}) begin
              spi_state_next = SPI_READ;
            end else if (in_byte == {MODE_CMD, CMD_CLR_A} || in_byte == {MODE_CMD, CMD_CLR_B}) begin
              cmd_clear = ctrl_reg.en; // stays in command state so it chains
            end else begin
              spi_state_next = SPI_SKIP; // other traffic is not this block's
            end
          end
          SPI_LOAD: spi_wr = 1'b1;
          SPI_READ: spi_rd = 1'b1; // pop only once all eight bits left
          default: ;
        endcase
      end
    end else if (spi_state_reg == SPI_READ && bit_cnt_reg == 3'h0) begin
      out_shift_next = empty ? 8'h00 : head; // byte not yet popped, so a cut one repeats
    end else if (sclk_fall) begin
      out_shift_next = {out_shift_reg[6:0], 1'b0};
    end
    miso_oe_n_next = ~(spi_state_next == SPI_READ);

    // fifo: one write port and one read port; rx wins the write port, tx the read port
    fifo_clear = cmd_clear | rx_start_i;
    wr_en  = rx_byte_valid_i | spi_wr;
    wdata  = rx_byte_valid_i ? rx_byte_i : in_byte;
    rd_en  = tx_req_i | spi_rd;
    do_wr  = wr_en & ~full & ~fifo_clear;
    do_rd  = rd_en & ~empty & ~fifo_clear;
    ovr_ev = wr_en & full;
    unf_ev = rd_en & empty; // host or transmitter ran dry
    wr_ptr_next = do_wr ? ((wr_ptr_reg == CNT_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_reg + 7'h1)
                        : wr_ptr_reg;
    rd_ptr_next = do_rd ? ((rd_ptr_reg == CNT_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_reg + 7'h1)
                        : rd_ptr_reg;
    count_next  = count_reg;
    if (do_wr && !do_rd) count_next = count_reg + 7'h1;
    if (do_rd && !do_wr) count_next = count_reg - 7'h1;
    load_cnt_next = (spi_wr && do_wr) ? load_cnt_reg + 13'h1 : load_cnt_reg;
    if (fifo_clear) begin
      wr_ptr_next   = '0;
      rd_ptr_next   = '0;
      count_next    = '0;
      load_cnt_next = '0;
    end
    tx_valid_next = tx_req_i & do_rd;
    tx_data_next  = (tx_req_i & do_rd) ? head : tx_data_reg;

    // water level events
    wl_rx     = ctrl_reg.wl_rx_sel ? WL_RX_1 : WL_RX_0;
    wl_tx     = ctrl_reg.wl_tx_sel ? WL_TX_1 : WL_TX_0;
    loaded    = (load_cnt_reg >= ntx_reg);
    fifo_mode = (spi_state_reg == SPI_LOAD) || (spi_state_reg == SPI_READ);
    wl_ev = 1'b0;
    if (tx_active_i && !loaded && count_reg == wl_tx + 7'h1 && count_next == wl_tx)
      wl_ev = 1'b1;
    if (tx_active_i && !loaded && load_cnt_reg < NTX_W'(wl_tx)
        && count_reg >= TX_LOW_MRK && count_next < TX_LOW_MRK)
      wl_ev = 1'b1;
    if (rx_active_i && count_reg == wl_rx - 7'h1 && count_next == wl_rx)
      wl_ev = 1'b1;
    if (fifo_mode || fifo_clear) wl_ev = 1'b0;

    // axi write channel: take address and data in either order, answer when both held
    widx = decode(aw_addr_reg);
    ridx = decode(araddr_i);
    aw_have_next = aw_have_reg | (awvalid_i & awready_reg);
    aw_addr_next = (awvalid_i & awready_reg) ? awaddr_i : aw_addr_reg;
    w_have_next  = w_have_reg | (wvalid_i & wready_reg);
    w_data_next  = (wvalid_i & wready_reg) ? wdata_i : w_data_reg;
    w_strb_next  = (wvalid_i & wready_reg) ? wstrb_i : w_strb_reg;
    bvalid_next  = bvalid_reg & ~bready_i;
    bresp_next   = bresp_reg;
    ctrl_next    = ctrl_reg;
    ntx_next     = ntx_reg;
    imask_next   = imask_reg;
    istat_next   = istat_reg;
    fstat2_next  = fstat2_reg;
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (widx == RI_CTRL) begin
        ctrl_next = ctrl_t'(merge(32'(ctrl_reg), w_data_reg, w_strb_reg));
      end else if (widx == RI_NTX) begin
        ntx_next = NTX_W'(merge(32'(ntx_reg), w_data_reg, w_strb_reg));
      end else if (widx == RI_ISTAT) begin
        if (w_strb_reg[0]) istat_next = istat_reg & ~w_data_reg[IRQ_W-1:0];
      end else if (widx == RI_IMASK) begin
        imask_next = IRQ_W'(merge(32'(imask_reg), w_data_reg, w_strb_reg));
      end else if (widx == RI_NONE) begin
        bresp_next = RESP_SLVER;
      end
    end
    awready_next = ~aw_have_next & ~bvalid_next;
    wready_next  = ~w_have_next & ~bvalid_next;

    // axi read channel: one cycle from address taken to data valid
    rvalid_next = rvalid_reg & ~rready_i;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (arvalid_i && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = 32'h0;
      if (ridx == RI_CTRL) begin
        rdata_next = 32'(ctrl_reg);
      end else if (ridx == RI_NTX) begin
        rdata_next = 32'(ntx_reg);
      end else if (ridx == RI_FSTAT1) begin
        rdata_next = 32'(count_reg); // live occupancy
      end else if (ridx == RI_FSTAT2) begin
        rdata_next = 32'(fstat2_reg);
        fstat2_next.last_byte_incomplete  = 1'b0;
        fstat2_next.last_byte_valid_bits  = 3'h0;
        fstat2_next.last_byte_parity_flag = 1'b0;
      end else if (ridx == RI_ISTAT) begin
        rdata_next = 32'(istat_reg);
      end else if (ridx == RI_IMASK) begin
        rdata_next = 32'(imask_reg);
      end else begin
        rresp_next = RESP_SLVER;
      end
    end
    arready_next = ~rvalid_next;

    // status flags: clears first, then hardware sets so a same-cycle event is kept
    if (fifo_clear) fstat2_next = FSTAT2_RST;
    if (rx_end_i) begin
      fstat2_next.last_byte_incomplete  = (rx_last_bits_i != 3'h0);
      fstat2_next.last_byte_valid_bits  = rx_last_bits_i;
      fstat2_next.last_byte_parity_flag = rx_parity_i;
    end
    if (ovr_ev) fstat2_next.overflow  = 1'b1;
    if (unf_ev) fstat2_next.underflow = 1'b1;
    istat_next[IRQ_WL]  = istat_next[IRQ_WL]  | wl_ev;
    istat_next[IRQ_OVR] = istat_next[IRQ_OVR] | ovr_ev;
    istat_next[IRQ_UNF] = istat_next[IRQ_UNF] | unf_ev;
    irq_next = |(istat_next & ~imask_next);
  end

  // state registers only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      load_cnt_reg  <= '0;
      spi_state_reg <= SPI_IDLE;
      bit_cnt_reg   <= 3'h0;
      in_shift_reg  <= 8'h00;
      out_shift_reg <= 8'h00;
      miso_oe_n_reg <= 1'b1;
      ctrl_reg      <= CTRL_RST;
      ntx_reg       <= '0;
      fstat2_reg    <= FSTAT2_RST;
      istat_reg     <= '0;
      imask_reg     <= IMASK_RST;
      irq_reg       <= 1'b0;
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_have_reg    <= 1'b0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      awready_reg   <= 1'b0;
      wready_reg    <= 1'b0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= RESP_OKAY;
      arready_reg   <= 1'b0;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h0;
      rresp_reg     <= RESP_OKAY;
      tx_data_reg   <= 8'h00;
      tx_valid_reg  <= 1'b0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      load_cnt_reg  <= load_cnt_next;
      spi_state_reg <= spi_state_next;
      bit_cnt_reg   <= bit_cnt_next;
      in_shift_reg  <= in_shift_next;
      out_shift_reg <= out_shift_next;
      miso_oe_n_reg <= miso_oe_n_next;
      ctrl_reg      <= ctrl_next;
      ntx_reg       <= ntx_next;
      fstat2_reg    <= fstat2_next;
      istat_reg     <= istat_next;
      imask_reg     <= imask_next;
      irq_reg       <= irq_next;
      aw_have_reg   <= aw_have_next;
      aw_addr_reg   <= aw_addr_next;
      w_have_reg    <= w_have_next;
      w_data_reg    <= w_data_next;
      w_strb_reg    <= w_strb_next;
      awready_reg   <= awready_next;
      wready_reg    <= wready_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      arready_reg   <= arready_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
      tx_data_reg   <= tx_data_next;
      tx_valid_reg  <= tx_valid_next;
    end
  end

  // every output straight from a flop
  assign awready_o   = awready_reg;
  assign wready_o    = wready_reg;
  assign bvalid_o    = bvalid_reg;
  assign bresp_o     = bresp_reg;
  assign arready_o   = arready_reg;
  assign rvalid_o    = rvalid_reg;
  assign rdata_o     = rdata_reg;
  assign rresp_o     = rresp_reg;
  assign miso_o      = out_shift_reg[7];
  assign miso_oe_n_o = miso_oe_n_reg;
  assign tx_data_o   = tx_data_reg;
  assign tx_valid_o  = tx_valid_reg;
  assign irq_o       = irq_reg;

endmodule

// ### testbench/frame_fifo_chk.sv
// port assertions for the frame fifo, bound to its top module
`timescale 1ns/1ps
module frame_fifo_chk
  import nfc_fifo_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // bus handshakes
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic        bvalid_o,
  input wire logic [7:0]  araddr_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  rresp_o,
  // serial select, data enable, transmit side
  input wire logic        ss_n_i,
  input wire logic        miso_oe_n_o,
  input wire logic        tx_req_i,
  input wire logic        tx_valid_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // a popped byte always answers a request one cycle earlier
  a_tx_pop_answer: assert property (tx_valid_o |-> $past(tx_req_i))
    else $error("tx byte without request");
  // synchroniser delay allowed before the port lets go of the data pin
  a_miso_idle: assert property (ss_n_i [*6] |-> miso_oe_n_o)
    else $error("data pin driven while deselected");
  a_miso_select: assert property (
    $fell(miso_oe_n_o) |-> !ss_n_i && $past(ss_n_i, 4) == 1'b0)
    else $error("data pin enabled without select");
  a_read_answer: assert property (
    arvalid_i && arready_o |=> rvalid_o && !arready_o)
    else $error("read not answered next cycle");
  a_read_holds: assert property (
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped early");
  a_read_hole: assert property (
    arvalid_i && arready_o && araddr_i == 8'h1c |=> rresp_o == RESP_SLVER && rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_write_answer: assert property (
    awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:2] bvalid_o)
    else $error("write not answered");
  a_write_busy: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write taken while answer pending");
  // main scenarios reached
  c_tx_pop: cover property (tx_valid_o);
  c_fifo_read: cover property ($fell(miso_oe_n_o));
  c_hole: cover property (arvalid_i && arready_o && araddr_i == 8'h1c);
endmodule
bind nfc_frame_fifo frame_fifo_chk i_chk (.*);

// ### testbench/spi_host_model.sv
// behavioural serial host for the frame fifo port
`timescale 1ns/1ps
module spi_host_model (
  // serial pins toward the block
  output logic      sclk_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  // data back and its active low enable
  input  wire logic miso_i,
  input  wire logic miso_oe_n_i
);
  localparam realtime HALF = 62.5ns; // 125 ns link clock, fast against air rate
  logic last_bit; // last level seen on the data pin
  initial begin
    sclk_o = 1'b0; // clock stands still outside frames
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
    last_bit = 1'b0;
  end
  // select low, settle before the first clock
  task automatic open();
    ss_n_o = 1'b0;
    #100ns;
  endtask
  // one byte msb first; fewer bits leave a partial byte behind
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, input int nb = 8);
    q = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      mosi_o = d[i];
      #HALF;
      sclk_o = 1'b1;
      // a released pin carries nothing: inverse of last bit
      last_bit = miso_oe_n_i ? ~last_bit : miso_i;
      q[i] = last_bit;
      #HALF;
      sclk_o = 1'b0;
    end
    mosi_o = ~mosi_o; // past hold time the old bit is gone
  endtask
  // select raised after each access so fifo mode ends
  task automatic close();
    #300ns;
    ss_n_o = 1'b1;
    #200ns;
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the frame fifo
`timescale 1ns/1ps
module testbench
  import nfc_fifo_pkg::*;
;
  logic        ref_clk_i, rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic        rx_active_i, rx_start_i, rx_byte_valid_i, rx_end_i, rx_parity_i;
  logic        tx_active_i, tx_req_i, sclk_i, ss_n_i, mosi_i;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, miso_o, miso_oe_n_o;
  logic        tx_valid_o, irq_o;
  logic [1:0]  bresp_o, rresp_o;
  logic [2:0]  rx_last_bits_i;
  logic [7:0]  awaddr_i, araddr_i, rx_byte_i, tx_data_o, q;
  logic [31:0] wdata_i, rdata_o;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  // full byte lanes always; lane tests are not in scope here
  nfc_frame_fifo i_dut (.*, .wstrb_i(4'hf));
  spi_host_model i_host (.sclk_o(sclk_i), .ss_n_o(ss_n_i), .mosi_o(mosi_i),
                         .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o));
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write: both channels offered, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw;
    @(posedge ref_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      ta = awvalid_i && (awready_o === 1'b1);
      tw = wvalid_i && (wready_o === 1'b1);
      @(posedge ref_clk_i);
      if (ta) awvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
    end while ((awvalid_i && !ta) || (wvalid_i && !tw));
    do @(negedge ref_clk_i); while (bvalid_o !== 1'b1);
    chk(32'(bresp_o), 32'(er));
    @(posedge ref_clk_i);
    bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
    @(posedge ref_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do @(negedge ref_clk_i); while (arready_o !== 1'b1);
    @(posedge ref_clk_i);
    arvalid_i <= 1'b0;
    do @(negedge ref_clk_i); while (rvalid_o !== 1'b1);
    chk(rdata_o, ed);
    chk(32'(rresp_o), 32'(er));
    @(posedge ref_clk_i);
    rready_i <= 1'b0;
  endtask
  task automatic rx_put(input logic [7:0] b);
    @(posedge ref_clk_i);
    rx_byte_i <= b;
    rx_byte_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_byte_valid_i <= 1'b0;
  endtask
  task automatic rx_begin();
    @(posedge ref_clk_i);
    rx_start_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_start_i <= 1'b0;
  endtask
  // transmitter pop; an empty fifo must give no byte
  task automatic pop(input logic v, input logic [7:0] e);
    @(posedge ref_clk_i);
    tx_req_i <= 1'b1;
    @(posedge ref_clk_i);
    tx_req_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(32'({tx_valid_o, v ? tx_data_o : 8'h00}), 32'({v, e}));
  endtask
  // one frame: command, optional chained code, optional read of nb bits
  task automatic frame(input logic [7:0] c1, input logic [7:0] c2, input int nb);
    i_host.open();
    i_host.xfer(c1, q);
    if (c2 != 8'h00) i_host.xfer(c2, q);
    if (nb > 0) i_host.xfer(8'h00, q, nb);
    i_host.close();
  endtask
  task automatic load(input int n, input logic [7:0] base);
    i_host.open();
    i_host.xfer({MODE_FIFO, CODE_LOAD}, q);
    for (int i = 0; i < n; i++) i_host.xfer(base + 8'(i), q);
    i_host.close();
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the ~70 us of traffic
  initial begin
    #300us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, rx_active_i, rx_start_i} = '0;
    {rx_byte_valid_i, rx_end_i, rx_parity_i, tx_active_i, tx_req_i} = '0;
    {awaddr_i, araddr_i, rx_byte_i, wdata_i, rx_last_bits_i} = '0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped hole, read-only status
    rd(OFF_CTRL, 32'h0);
    rd(OFF_IMASK, 32'h0);
    rd(8'h1c, 32'h0, RESP_SLVER);
    wr(8'h1c, 32'h1, RESP_SLVER);
    wr(OFF_FSTAT1, 32'h7f);
    rd(OFF_FSTAT1, 32'h0);
    // reception: level crossing, capacity, overflow under mask
    rx_active_i <= 1'b1;
    rx_begin();
    for (int i = 0; i < 63; i++) rx_put(8'(i) + 8'h40);
    rd(OFF_ISTAT, 32'h0);
    rx_put(8'h7f);
    rd(OFF_ISTAT, 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(OFF_ISTAT, 32'h1);
    chk(32'(irq_o), 32'h0);
    wr(OFF_IMASK, 32'h2);
    for (int i = 0; i < 32; i++) rx_put(8'(i) + 8'h80);
    rd(OFF_FSTAT1, 32'd96);
    rx_put(8'hff);
    rd(OFF_ISTAT, 32'h2);
    chk(32'(irq_o), 32'h0);
    wr(OFF_IMASK, 32'h0);
    chk(32'(irq_o), 32'h1);
    wr(OFF_ISTAT, 32'h2);
    @(posedge ref_clk_i);
    rx_last_bits_i <= 3'h3;
    rx_parity_i <= 1'b1;
    rx_end_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_end_i <= 1'b0;
    rx_active_i <= 1'b0;
    rd(OFF_FSTAT2, 32'h37);
    rd(OFF_FSTAT2, 32'h20);
    // host reads, a broken byte is returned again
    frame({MODE_FIFO, CODE_READ}, 8'h00, 8);
    chk(32'(q), 32'h40);
    frame({MODE_FIFO, CODE_READ}, 8'h00, 8);
    chk(32'(q), 32'h41);
    rd(OFF_FSTAT1, 32'd94);
    frame({MODE_FIFO, CODE_READ}, 8'h00, 4);
    frame({MODE_FIFO, CODE_READ}, 8'h00, 8);
    chk(32'(q), 32'h42);
    // clear ignored while disabled, then chained with a read of empty
    frame({MODE_CMD, CMD_CLR_A}, 8'h00, 0);
    rd(OFF_FSTAT1, 32'd93);
    wr(OFF_CTRL, 32'h1);
    frame({MODE_CMD, CMD_CLR_B}, {MODE_FIFO, CODE_READ}, 8);
    chk(32'(q), 32'h0);
    rd(OFF_FSTAT1, 32'h0);
    rd(OFF_FSTAT2, 32'h40);
    wr(OFF_ISTAT, 32'h7);
    // transmit: in-order drain, falling level, late host
    wr(OFF_NTX, 32'd40);
    frame({MODE_CMD, CMD_CLR_A}, 8'h00, 0);
    load(34, 8'h20);
    wr(OFF_ISTAT, 32'h7);
    tx_active_i <= 1'b1;
    pop(1'b1, 8'h20);
    rd(OFF_ISTAT, 32'h0);
    pop(1'b1, 8'h21);
    rd(OFF_ISTAT, 32'h1);
    wr(OFF_ISTAT, 32'h1);
    for (int i = 2; i < 34; i++) pop(1'b1, 8'(i) + 8'h20);
    pop(1'b0, 8'h00);
    rd(OFF_ISTAT, 32'h4);
    rd(OFF_FSTAT2, 32'h40);
    // short frame with the second tx level: interrupt below four
    tx_active_i <= 1'b0;
    wr(OFF_CTRL, 32'h5);
    frame({MODE_CMD, CMD_CLR_A}, 8'h00, 0);
    load(6, 8'h30);
    wr(OFF_ISTAT, 32'h7);
    tx_active_i <= 1'b1;
    pop(1'b1, 8'h30);
    pop(1'b1, 8'h31);
    rd(OFF_ISTAT, 32'h0);
    pop(1'b1, 8'h32);
    rd(OFF_ISTAT, 32'h1);
    // new reception empties; level crossing hidden by fifo mode
    tx_active_i <= 1'b0;
    rx_active_i <= 1'b1;
    rx_begin();
    rd(OFF_FSTAT1, 32'h0);
    wr(OFF_ISTAT, 32'h7);
    for (int i = 0; i < 63; i++) rx_put(8'(i));
    i_host.open();
    i_host.xfer({MODE_FIFO, CODE_READ}, q);
    rx_put(8'h3f);
    i_host.close();
    rd(OFF_ISTAT, 32'h0);
    finish_test();
  end
endmodule
